// ===== hdl/simd_fp_exc_pkg.sv
// Shared constants and carrier types of the SIMD floating-point exception unit.
package simd_fp_exc_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [3:0] OFS_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
  localparam logic [3:0] OFS_UNIT_STATE = 4'hc;

  // Condition order inside the six-bit flag and mask groups.
  localparam int COND_INVALID = 0;
  localparam int COND_DENORMAL = 1;
  localparam int COND_DIV_ZERO = 2;
  localparam int COND_OVERFLOW = 3;
  localparam int COND_UNDERFLOW = 4;
  localparam int COND_INEXACT = 5;
  localparam int NUM_COND = 6;

  // Field positions of the control/status register.
  localparam int CSR_FLAG_LSB = 0;
  localparam int CSR_DAZ_BIT = 6;
  localparam int CSR_MASK_LSB = 7;
  localparam int CSR_ROUND_LSB = 13;
  localparam int CSR_FTZ_BIT = 15;
  localparam int CSR_USED_BITS = 16;

  // Reset value: all six masks set, all flags clear.
  localparam logic [31:0] CSR_RESET = 32'h0000_1f80;

  // Bits of the pre-computation and post-computation groups in a six-bit vector.
  localparam logic [5:0] PRE_GROUP = 6'h07;
  localparam logic [5:0] POST_GROUP = 6'h38;

  // Interrupt event positions.
  localparam int EV_PRE_FAULT = 0;
  localparam int EV_POST_FAULT = 1;
  localparam int EV_MASKED_SET = 2;
  localparam int NUM_EV = 3;

  // Operation classes presented by the datapath with each issue.
  typedef enum logic [2:0] {
    OPC_ARITH,
    OPC_DIVIDE,
    OPC_NARROW,
    OPC_CONVERT_INT,
    OPC_RECIP_APPROX,
    OPC_OTHER
  } op_class_t;

  // Fault kinds delivered to the instruction sequencer.
  typedef enum logic {
    FAULT_SIMD_FP,
    FAULT_INVALID_OPCODE
  } fault_kind_t;

  // Per-lane operand classification, valid with the issue strobe.
  typedef struct packed {
    logic den_a;
    logic den_b;
    logic sign_a;
    logic sign_b;
    logic dividend_finite_nz;
    logic divisor_zero;
    logic invalid;
  } lane_pre_t;

  // Per-lane rounded result classification, valid with the result strobe.
  typedef struct packed {
    logic overflow;
    logic tiny;
    logic inexact;
    logic sign;
  } lane_post_t;

  // Per-lane substitution orders back to the datapath.
  typedef struct packed {
    logic zero_a;
    logic sign_a;
    logic zero_b;
    logic sign_b;
    logic zero_res;
    logic sign_res;
  } lane_fix_t;

endpackage : simd_fp_exc_pkg

// ===== hdl/fp_lane_check.sv
// Condition classifier for one lane of a packed or scalar operation.
`timescale 1ns/1ns
module fp_lane_check
  import simd_fp_exc_pkg::*;
(
  input wire op_class_t op_i,
  input wire lane_pre_t pre_i,
  input wire lane_post_t post_i,
  input wire logic daz_i,
  input wire logic underflow_mask_i,
  output logic [NUM_COND-1:0] cond_o
);

  // Operation groups that decide which conditions can arise at all.
  wire is_quiet = (op_i == OPC_RECIP_APPROX);
  wire is_cvt_int = (op_i == OPC_CONVERT_INT);
  wire is_div = (op_i == OPC_DIVIDE);
  wire rounds_range = (op_i == OPC_ARITH) || is_div || (op_i == OPC_NARROW);

  // Denormal sources replaced under denormals-as-zero are never consumed, so no flag.
  wire den_seen = (pre_pick(pre_i.den_a, pre_i.den_b)) && !daz_i;

  // Underflow is reported for tiny alone only while it is unmasked.
  wire unf_seen = post_i.tiny && (!underflow_mask_i || post_i.inexact);

  function automatic logic pre_pick(input logic a, input logic b);
    pre_pick = a | b;
  endfunction : pre_pick

  // Condition vector; the approximate reciprocal class raises nothing.
  assign cond_o[COND_INVALID] = pre_i.invalid && !is_quiet;
  assign cond_o[COND_DENORMAL] = den_seen && !is_cvt_int && !is_quiet; // RULE_01 RULE_02 RULE_03 RULE_05
  assign cond_o[COND_DIV_ZERO] = is_div && pre_i.dividend_finite_nz && pre_i.divisor_zero; // RULE_06
  assign cond_o[COND_OVERFLOW] = rounds_range && post_i.overflow; // RULE_07
  assign cond_o[COND_UNDERFLOW] = rounds_range && unf_seen; // RULE_08 RULE_13
  assign cond_o[COND_INEXACT] = post_i.inexact && !is_quiet; // RULE_10

endmodule : fp_lane_check

// ===== hdl/fp_irq_sticky.sv
// Sticky interrupt status with mask and one level interrupt output.
`timescale 1ns/1ns
module fp_irq_sticky
  import simd_fp_exc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [NUM_EV-1:0] event_i,
  input wire logic status_rd_i,
  input wire logic mask_wr_i,
  input wire logic [NUM_EV-1:0] mask_wdata_i,
  output logic [NUM_EV-1:0] status_o,
  output logic [NUM_EV-1:0] mask_o,
  output logic irq_o
);

  logic [NUM_EV-1:0] status_q;
  logic [NUM_EV-1:0] mask_q;
  logic [NUM_EV-1:0] status_d;

  // A read clears the status, but an event in the same cycle survives it.
  assign status_d = (status_rd_i ? '0 : status_q) | event_i;

  // Status and mask hold while the clock enable is low.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_q <= '0;
      mask_q <= '0;
    end
    else if (ce_i)
    begin
      status_q <= status_d;
      if (mask_wr_i)
      begin
        mask_q <= mask_wdata_i;
      end
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = |(status_q & mask_q);

endmodule : fp_irq_sticky

// ===== hdl/simd_fp_exception_unit.sv
// Exception detection, flag recording and fault sequencing for SIMD floating-point operations.
//
// Function
// RULE_01: A consumed denormal source sets flag bit 1; mask bit 8 suppresses the fault.
// RULE_02: Integer/float conversions, truncating ones too, never raise the denormal condition.
// RULE_03: Approximate reciprocal and reciprocal square root raise no condition at all.
// RULE_04: With bit 6 set, denormal sources become zeros keeping their sign.
// RULE_05: Denormal detection ignores the flush-to-zero setting.
// RULE_06: Divide of finite non-zero by zero raises flag 2, mask 9.
// RULE_07: Range-rounding operations raise overflow, flag 3, mask 10, above largest finite.
// RULE_08: Underflow flag 4, mask 11; when masked only tiny and inexact counts.
// RULE_09: With bit 15 and underflow masked, tiny results become signed zeros.
// RULE_10: Inexact raises whenever a result is not exact, mask bit 12.
// RULE_11: The inexact flag sits at bit 5; flags fill bits 0 to 5.
// RULE_12: Pre-computation conditions are checked before post-computation conditions.
// RULE_13: Masked conditions set flags; tiny without inexact leaves underflow clear.
// RULE_14: Conditions are found per lane and ORed into the sticky flags.
// RULE_15: Unmasked pre conditions set flags, hold operands, dispatch; else go compute.
// RULE_16: Dispatch raises the SIMD fault if OS support is set, else invalid opcode.
// RULE_17: After pre-fault return, check post; unmasked post gives a second fault.
// RULE_18: Mixed masked and unmasked set all flags; results written after last return.
// RULE_19: Reset sets mask bits 7 to 12 and clears flag bits 0 to 5.
`timescale 1ns/1ns
module simd_fp_exception_unit
  import simd_fp_exc_pkg::*;
#(
  parameter int NUM_LANES = 4
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Operating-system support bit of control register four.
  input wire logic os_simd_fault_support_i,
  // Issue of one instruction with its operand classification.
  input wire logic issue_i,
  input wire op_class_t issue_op_i,
  input wire logic [NUM_LANES-1:0] lane_en_i,
  input wire lane_pre_t [NUM_LANES-1:0] lane_pre_i,
  output logic issue_ready_o,
  // Computation permission and rounded results.
  output logic compute_go_o,
  input wire logic result_valid_i,
  input wire lane_post_t [NUM_LANES-1:0] lane_post_i,
  // Substitution orders, operand hold, commit and fault dispatch.
  output lane_fix_t [NUM_LANES-1:0] lane_fix_o,
  output logic hold_operands_o,
  output logic commit_o,
  output logic fault_o,
  output fault_kind_t fault_kind_o,
  output logic fault_post_o,
  input wire logic handler_return_i,
  output logic irq_o
);

  // Lane count must fit the packed carriers and stay meaningful.
  if (NUM_LANES < 1 || NUM_LANES > 16)
  begin : g_lane_check
    $error("NUM_LANES must lie between 1 and 16.");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE_FAULT,
    ST_COMPUTE,
    ST_POST_FAULT
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [31:0] csr_q;
  logic [31:0] csr_d;
  op_class_t op_q;
  logic [NUM_LANES-1:0] lane_en_q;
  logic daz_q;
  lane_fix_t [NUM_LANES-1:0] fix_q;
  lane_fix_t [NUM_LANES-1:0] fix_d;
  logic commit_q;
  logic fault_q;
  fault_kind_t fault_kind_q;
  logic fault_post_q;
  logic [31:0] rdata_q;

  // Field views of the control/status register.
  wire [NUM_COND-1:0] csr_flags = csr_q[CSR_FLAG_LSB +: NUM_COND];
  wire [NUM_COND-1:0] csr_masks = csr_q[CSR_MASK_LSB +: NUM_COND];
  wire csr_daz = csr_q[CSR_DAZ_BIT];
  wire csr_ftz = csr_q[CSR_FTZ_BIT];

  // Per-lane classification feeding the OR across lanes.
  logic [NUM_COND-1:0] lane_cond [NUM_LANES];
  logic [NUM_COND-1:0] or_cond [NUM_LANES+1];
  op_class_t eval_op;
  logic eval_daz;

  // The pre check classifies the issuing operation; later checks use the latched one.
  assign eval_op = (state_q == ST_IDLE) ? issue_op_i : op_q;
  assign eval_daz = (state_q == ST_IDLE) ? csr_daz : daz_q;
  assign or_cond[0] = '0;

  genvar gl;
  generate
    for (gl = 0; gl < NUM_LANES; gl++)
    begin : g_lane
      wire lane_on = (state_q == ST_IDLE) ? lane_en_i[gl] : lane_en_q[gl];

      fp_lane_check u_check (
        .op_i(eval_op),
        .pre_i(lane_pre_i[gl]),
        .post_i(lane_post_i[gl]),
        .daz_i(eval_daz),
        .underflow_mask_i(csr_masks[COND_UNDERFLOW]),
        .cond_o(lane_cond[gl])
      );

      // Disabled lanes of a scalar operation contribute nothing.
      assign or_cond[gl+1] = or_cond[gl] | (lane_on ? lane_cond[gl] : '0); // RULE_14

      // Substitution orders: signed zero for denormal sources and flushed tiny results.
      always_comb
      begin
        fix_d[gl] = fix_q[gl];
        if (state_q == ST_IDLE && issue_i)
        begin
          fix_d[gl] = '0;
          fix_d[gl].zero_a = csr_daz && lane_pre_i[gl].den_a; // RULE_04
          fix_d[gl].sign_a = lane_pre_i[gl].sign_a;
          fix_d[gl].zero_b = csr_daz && lane_pre_i[gl].den_b; // RULE_04
          fix_d[gl].sign_b = lane_pre_i[gl].sign_b;
        end
        else if (state_q == ST_COMPUTE && result_valid_i)
        begin
          fix_d[gl].zero_res = csr_ftz && csr_masks[COND_UNDERFLOW] && lane_post_i[gl].tiny; // RULE_09
          fix_d[gl].sign_res = lane_post_i[gl].sign;
        end
      end
    end
  endgenerate

  // Conditions of each phase and their unmasked part.
  wire [NUM_COND-1:0] pre_cond = or_cond[NUM_LANES] & PRE_GROUP;
  wire [NUM_COND-1:0] post_cond = or_cond[NUM_LANES] & POST_GROUP;
  wire pre_unmasked = |(pre_cond & ~csr_masks);
  wire post_unmasked = |(post_cond & ~csr_masks);

  // Strobes of the two checks; the post check only runs after the pre phase is over.
  wire issue_take = ce_i && issue_i && (state_q == ST_IDLE);
  wire result_take = ce_i && result_valid_i && (state_q == ST_COMPUTE); // RULE_12
  wire pre_return = ce_i && handler_return_i && (state_q == ST_PRE_FAULT);
  wire post_return = ce_i && handler_return_i && (state_q == ST_POST_FAULT);

  // Flags that hardware sets this cycle, masked and unmasked alike.
  wire [NUM_COND-1:0] hw_set = (issue_take ? pre_cond : '0)
                             | (result_take ? post_cond : '0); // RULE_13 RULE_18
  wire masked_set = |(hw_set & csr_masks);
  wire raise_fault = (issue_take && pre_unmasked) || (result_take && post_unmasked);

  // Sequencer: pre check, optional fault, compute, post check, optional fault, commit.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (issue_i)
        begin
          state_d = pre_unmasked ? ST_PRE_FAULT : ST_COMPUTE; // RULE_15
        end
      end
      ST_PRE_FAULT:
      begin
        if (handler_return_i)
        begin
          state_d = ST_COMPUTE; // RULE_17
        end
      end
      ST_COMPUTE:
      begin
        if (result_valid_i)
        begin
          state_d = post_unmasked ? ST_POST_FAULT : ST_IDLE; // RULE_17
        end
      end
      ST_POST_FAULT:
      begin
        if (handler_return_i)
        begin
          state_d = ST_IDLE; // RULE_18
        end
      end
    endcase
  end

  // Register decode.
  wire wr_csr = ce_i && reg_wr_i && (reg_addr_i == OFS_CONTROL_STATUS);
  wire wr_irq_mask = ce_i && reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);
  wire rd_irq_status = ce_i && reg_rd_i && (reg_addr_i == OFS_IRQ_STATUS);
  wire [31:0] csr_wvalue = {16'h0000, reg_wdata_i[CSR_USED_BITS-1:0]};

  // Software writes first; hardware-set flags are ORed after, so a set wins.
  assign csr_d = (wr_csr ? csr_wvalue : csr_q)
               | {26'h0000000, hw_set}; // RULE_11 RULE_13

  // Interrupt events.
  logic [NUM_EV-1:0] irq_event;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_mask;

  assign irq_event[EV_PRE_FAULT] = issue_take && pre_unmasked;
  assign irq_event[EV_POST_FAULT] = result_take && post_unmasked;
  assign irq_event[EV_MASKED_SET] = masked_set;

  fp_irq_sticky u_irq (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .event_i(irq_event),
    .status_rd_i(rd_irq_status),
    .mask_wr_i(wr_irq_mask),
    .mask_wdata_i(reg_wdata_i[NUM_EV-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // Read data selection; unmapped offsets read zero.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr_i)
      OFS_CONTROL_STATUS: rd_mux = csr_q;
      OFS_IRQ_STATUS: rd_mux = {29'h00000000, irq_status};
      OFS_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
      OFS_UNIT_STATE: rd_mux = {30'h00000000, state_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Control/status register and sequencer state.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      csr_q <= CSR_RESET; // RULE_19
      state_q <= ST_IDLE;
    end
    else if (ce_i)
    begin
      csr_q <= csr_d;
      state_q <= state_d;
    end
  end

  // Instruction context latched at issue so the later phases see the same operation.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q <= OPC_OTHER;
      lane_en_q <= '0;
      daz_q <= 1'b0;
      fix_q <= '0;
    end
    else if (ce_i)
    begin
      fix_q <= fix_d;
      if (issue_take)
      begin
        op_q <= issue_op_i;
        lane_en_q <= lane_en_i;
        daz_q <= csr_daz;
      end
    end
  end

  // Fault dispatch picks its kind from the OS support bit at the moment of raising.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fault_q <= 1'b0;
      fault_kind_q <= FAULT_SIMD_FP;
      fault_post_q <= 1'b0;
      commit_q <= 1'b0;
    end
    else if (ce_i)
    begin
      fault_q <= raise_fault;
      commit_q <= (result_take && !post_unmasked) || post_return; // RULE_18
      if (raise_fault)
      begin
        fault_kind_q <= os_simd_fault_support_i ? FAULT_SIMD_FP : FAULT_INVALID_OPCODE; // RULE_16
        fault_post_q <= result_take;
      end
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // Operands stay untouched while a handler runs for either phase.
  assign hold_operands_o = (state_q == ST_PRE_FAULT) || (state_q == ST_POST_FAULT); // RULE_15 RULE_17
  assign compute_go_o = (state_q == ST_COMPUTE); // RULE_12
  assign issue_ready_o = (state_q == ST_IDLE);
  assign lane_fix_o = fix_q;
  assign commit_o = commit_q;
  assign fault_o = fault_q;
  assign fault_kind_o = fault_kind_q;
  assign fault_post_o = fault_post_q;
  assign reg_rdata_o = rdata_q;

  // The pre-fault return is consumed by the state change alone.
  wire unused_ok = pre_return;

endmodule : simd_fp_exception_unit

// ===== test/simd_fp_exc_props.sv
// Concurrent checks on the sequencing ports of the SIMD floating-point exception unit.
`timescale 1ns/1ns
module simd_fp_exc_props
  import simd_fp_exc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic os_simd_fault_support_i,
  input wire logic issue_i,
  input wire logic issue_ready_o,
  input wire logic compute_go_o,
  input wire logic result_valid_i,
  input wire logic hold_operands_o,
  input wire logic commit_o,
  input wire logic fault_o,
  input wire fault_kind_t fault_kind_o,
  input wire logic fault_post_o,
  input wire logic handler_return_i
);
  // One clock domain, so clock and reset are given once for every property.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  // An accepted issue is followed by computation or by a pre-computation fault.
  AST_ISSUE_STEP: assert property (
    issue_i && issue_ready_o && ce_i |=> (compute_go_o && !fault_o)
    || (fault_o && hold_operands_o && !fault_post_o))
    else $error("issue not followed by compute or pre fault");
  // A taken result either commits or raises a post-computation fault.
  AST_RESULT_STEP: assert property (
    result_valid_i && compute_go_o && ce_i |=> commit_o || (fault_o && fault_post_o))
    else $error("result not followed by commit or post fault");
  // Return from a pre-computation fault resumes with the computation.
  AST_PRE_RETURN: assert property (
    handler_return_i && hold_operands_o && !fault_post_o && ce_i |=> compute_go_o)
    else $error("pre fault return did not resume computation");
  // Return from a post-computation fault completes the instruction.
  AST_POST_RETURN: assert property (
    handler_return_i && hold_operands_o && fault_post_o && ce_i |=> commit_o && !fault_o)
    else $error("post fault return did not commit");
  // Masked results are written only after a result or the final handler return.
  AST_COMMIT_CAUSE: assert property (
    commit_o |-> $past(compute_go_o && result_valid_i && ce_i)
    || $past(hold_operands_o && handler_return_i && fault_post_o && ce_i))
    else $error("commit without a cause");
  // The fault kind follows the operating-system support bit.
  AST_FAULT_KIND: assert property (
    fault_o |-> fault_kind_o == ($past(os_simd_fault_support_i) ? FAULT_SIMD_FP
    : FAULT_INVALID_OPCODE))
    else $error("wrong fault kind");
  // A fault is a single pulse while the operands are held.
  AST_FAULT_PULSE: assert property (
    fault_o |-> hold_operands_o ##1 !fault_o)
    else $error("fault pulse too long or operands free");
  // Operands stay held until the handler returns.
  AST_HOLD_WAIT: assert property (
    hold_operands_o && !handler_return_i |=> hold_operands_o && !compute_go_o && !commit_o)
    else $error("hold released without a return");
endmodule : simd_fp_exc_props

bind simd_fp_exception_unit simd_fp_exc_props u_props (.mclk_i, .arst_n_i, .ce_i,
  .os_simd_fault_support_i, .issue_i, .issue_ready_o, .compute_go_o, .result_valid_i,
  .hold_operands_o, .commit_o, .fault_o, .fault_kind_o, .fault_post_o, .handler_return_i);

// ===== test/fp_datapath_model.sv
// Behavioural model of the datapath and fault handler facing the exception unit.
`timescale 1ns/1ns
module fp_datapath_model
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] delay_i,
  input wire logic compute_go_i,
  input wire logic hold_operands_i,
  output logic result_valid_o,
  output logic handler_return_o
);
  logic [3:0] wait_q;

  // Answers are one-cycle pulses after delay_i idle cycles, so the far side can be slow.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_q <= 4'h0;
      result_valid_o <= 1'b0;
      handler_return_o <= 1'b0;
    end
    else if (result_valid_o || handler_return_o)
    begin
      result_valid_o <= 1'b0;
      handler_return_o <= 1'b0;
      wait_q <= 4'h0;
    end
    else if ((compute_go_i || hold_operands_i) && wait_q != delay_i)
      wait_q <= wait_q + 4'h1;
    else
    begin
      result_valid_o <= compute_go_i;
      handler_return_o <= hold_operands_i;
    end
  end
endmodule : fp_datapath_model

// ===== test/simd_fp_exception_unit_bench.sv
// Self-checking bench of the SIMD floating-point exception unit.
`timescale 1ns/1ns
module simd_fp_exception_unit_bench
  import simd_fp_exc_pkg::*;
;
  logic mclk_i;
  logic arst_n_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic os_simd_fault_support_i;
  logic issue_i;
  op_class_t issue_op_i;
  logic [3:0] lane_en_i;
  lane_pre_t [3:0] lane_pre_i;
  lane_post_t [3:0] lane_post_i;
  lane_fix_t [3:0] lane_fix_o;
  logic issue_ready_o;
  logic compute_go_o;
  logic result_valid_i;
  logic hold_operands_o;
  logic commit_o;
  logic fault_o;
  fault_kind_t fault_kind_o;
  logic fault_post_o;
  logic handler_return_i;
  logic irq_o;
  logic [3:0] delay;
  int num_errors;
  int checks_done;
  int faults;

  simd_fp_exception_unit #(.NUM_LANES(4)) dut (.mclk_i, .arst_n_i, .ce_i(1'b1), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .os_simd_fault_support_i, .issue_i,
    .issue_op_i, .lane_en_i, .lane_pre_i, .issue_ready_o, .compute_go_o, .result_valid_i,
    .lane_post_i, .lane_fix_o, .hold_operands_o, .commit_o, .fault_o, .fault_kind_o,
    .fault_post_o, .handler_return_i, .irq_o);

  fp_datapath_model partner (.mclk_i, .arst_n_i, .delay_i(delay), .compute_go_i(compute_go_o),
    .hold_operands_i(hold_operands_o), .result_valid_o(result_valid_i),
    .handler_return_o(handler_return_i));

  // Free-running 100 MHz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Counts fault pulses; sampled at the edge, before the design's updates land.
  always @(posedge mclk_i)
    if (fault_o === 1'b1)
      faults++;

  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Strobes drop for one edge after each access so no signal is set twice in one step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask : rd

  // Sets the control word, issues one instruction, waits for commit and checks the flags.
  task automatic trial(input logic [31:0] cin, input op_class_t op, input logic [3:0] en,
                       input logic [27:0] pre, input logic [15:0] post, input int nf,
                       input logic [31:0] cout);
    int i;
    wr(OFS_CONTROL_STATUS, cin);
    faults = 0;
    issue_op_i <= op;
    lane_en_i <= en;
    lane_pre_i <= pre;
    lane_post_i <= post;
    issue_i <= 1'b1;
    @(posedge mclk_i);
    issue_i <= 1'b0;
    i = 0;
    while (commit_o !== 1'b1 && i < 60)
    begin
      @(posedge mclk_i);
      i++;
    end
    chk(32'(commit_o), 32'h1);
    chk(32'(faults), 32'(nf));
    rd(OFS_CONTROL_STATUS, cout);
  endtask : trial

  // Hang guard, far beyond the roughly 130 cycles the sequence needs.
  initial
  begin
    #100000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    arst_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    os_simd_fault_support_i = 1'b1;
    issue_i = 1'b0;
    issue_op_i = OPC_OTHER;
    lane_en_i = 4'hf;
    lane_pre_i = '0;
    lane_post_i = '0;
    delay = 4'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFS_CONTROL_STATUS, 32'h0000_1f80);
    rd(4'h2, 32'h0);
    rd(OFS_UNIT_STATE, 32'h0);
    wr(OFS_IRQ_MASK, 32'h7);
    trial(32'h1f80, OPC_ARITH, 4'hf, 28'h40, 16'h6800, 0, 32'h1fba);
    rd(OFS_IRQ_STATUS, 32'h4);
    chk(32'(irq_o), 32'h0);
    trial(32'h9f80, OPC_ARITH, 4'hf, 28'h80000, 16'h0047, 0, 32'h9fb2);
    chk(32'(lane_fix_o[0]), 32'h03);
    trial(32'h1fc0, OPC_ARITH, 4'hf, 28'h50, 16'h0, 0, 32'h1fc0);
    chk(32'(lane_fix_o[0]), 32'h30);
    trial(32'h1e80, OPC_CONVERT_INT, 4'hf, 28'h1040, 16'h0, 0, 32'h1e80);
    trial(32'h0, OPC_RECIP_APPROX, 4'hf, {4{7'h6d}}, 16'heeee, 0, 32'h0);
    trial(32'h1d80, OPC_DIVIDE, 4'h7, 28'h1c00000, 16'h0, 0, 32'h1d80);
    delay <= 4'h3;
    trial(32'h9dc0, OPC_DIVIDE, 4'hf, 28'h700, 16'h0, 1, 32'h9dc4);
    chk(32'(fault_kind_o), 32'h0);
    rd(OFS_IRQ_STATUS, 32'h5);
    wr(OFS_IRQ_MASK, 32'h0);
    os_simd_fault_support_i <= 1'b0;
    delay <= 4'h0;
    trial(32'h1000, OPC_ARITH, 4'hf, 28'h40, 16'h0a00, 2, 32'h102a);
    chk(32'(fault_kind_o), 32'h1);
    chk(32'(fault_post_o), 32'h1);
    chk(32'(irq_o), 32'h0);
    wr(OFS_IRQ_MASK, 32'h7);
    chk(32'(irq_o), 32'h1);
    rd(OFS_IRQ_STATUS, 32'h7);
    chk(32'(irq_o), 32'h0);
    trial(32'h1b80, OPC_NARROW, 4'hf, 28'h0, 16'h0008, 1, 32'h1b88);
    trial(32'h1b80, OPC_OTHER, 4'hf, 28'h0, 16'h0008, 0, 32'h1b80);
    trial(32'h1780, OPC_ARITH, 4'hf, 28'h0, 16'h0004, 1, 32'h1790);
    end_sim();
  end
endmodule : simd_fp_exception_unit_bench
